// ===== fault_pkg.sv
// Constants for the flyback fault supervisor.
// Functional notes
// - Supply OV, brownout, output OV, overtemp: normal restart.
// - Output under-voltage enters extended auto-restart.
// - Restart stops switching; drive held off throughout.
// - Turn-off threshold in normal restart enters deep low current.
// - Re-enable threshold clears protection, enables startup source.
// - Turn-on threshold after clear resumes switching.
// - Supply OV needs flag held full debounce.
// - Low line current on-time beyond filter: brownout.
// - Overtemp flag disables drive, enters auto-restart.
// - Output OV on more than two consecutive cycles.
// - Sample under-voltage at diode conduction end.
// - Under-voltage beyond configured cycle count triggers fault.
// - Blank under-voltage detection after power-on.
// - Current limit comparator ends gate pulse.
// - Diode-short comparator ends pulse, even during blanking.
// - After diode short, restart at the next cycle start.
// - Sense short on more than two cycles: restart.
// - Extended restart cycles supply twice, then resumes.
package fault_pkg;
   // ===========================================
   // Timing
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned SUPPLY_OV_DEBOUNCE_NS = 70_000;
   localparam int unsigned BROWNOUT_FILTER_US = 16_500;
   localparam int unsigned UV_STARTUP_BLANK_US = 45_000;
   localparam int unsigned SUPPLY_OV_CYCLES = SUPPLY_OV_DEBOUNCE_NS / 5;
   localparam int unsigned BROWNOUT_CYCLES = BROWNOUT_FILTER_US * (CLK_HZ / 1_000_000);
   localparam int unsigned UV_BLANK_CYCLES = UV_STARTUP_BLANK_US * (CLK_HZ / 1_000_000);
   // ===========================================
   // Counts
   localparam int unsigned OVERVOLTAGE_CYCLE_COUNT = 2;
   localparam int unsigned SENSE_SHORT_CYCLE_COUNT = 2;
   localparam int unsigned EXTENDED_RESTART_LOOPS = 2;
   localparam logic [7:0] UNDERVOLTAGE_CYCLE_RESET = 8'h04;
   // ===========================================
   // Supervisor states
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_DIODE_WAIT = 3'b001,
      ST_RESTART = 3'b010,
      ST_DEEP = 3'b011,
      ST_CHARGE = 3'b100
   } sup_state_t;
endpackage : fault_pkg

// ===== flyback_fault_supervisor.sv
// Fault supervisor for a quasi-resonant flyback controller.
`timescale 1ns/10ps
module flyback_fault_supervisor #(
   parameter int unsigned BROWNOUT_CYC = fault_pkg::BROWNOUT_CYCLES,
   parameter int unsigned UV_BLANK_CYC = fault_pkg::UV_BLANK_CYCLES,
   parameter int unsigned CNT_W = 24
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic gate_req_i,
   input wire logic supply_ov_cmp_i,
   input wire logic line_low_cmp_i,
   input wire logic overtemp_cmp_i,
   input wire logic sense_ov_cmp_i,
   input wire logic sense_uv_cmp_i,
   input wire logic diode_end_i,
   input wire logic current_limit_cmp_i,
   input wire logic diode_short_cmp_i,
   input wire logic sense_short_cmp_i,
   input wire logic supply_off_thr_i,
   input wire logic startup_reenable_threshold_i,
   input wire logic supply_on_thr_i,
   input wire logic [7:0] undervoltage_cycle_count_i,
   output logic gate_o,
   output logic startup_source_en_o,
   output logic deep_low_current_state_o,
   output logic low_current_o,
   output logic restart_active_o,
   output logic extended_restart_o,
   output logic [5:0] fault_cause_o
);
   localparam int unsigned NSYNC = 15;
   localparam logic [CNT_W-1:0] OV_LIM = CNT_W'(fault_pkg::SUPPLY_OV_CYCLES);
   localparam logic [CNT_W-1:0] BO_LIM = CNT_W'(BROWNOUT_CYC);
   localparam logic [CNT_W-1:0] BL_LIM = CNT_W'(UV_BLANK_CYC);
   localparam logic [1:0] OVC_LIM = 2'(fault_pkg::OVERVOLTAGE_CYCLE_COUNT);
   localparam logic [1:0] SHC_LIM = 2'(fault_pkg::SENSE_SHORT_CYCLE_COUNT);
   localparam logic [1:0] EXT_LOOPS = 2'(fault_pkg::EXTENDED_RESTART_LOOPS);

   // ===========================================
   // Input synchronisers
   // Inputs pass three stages; a level is taken only when stages two and three agree.
   logic [NSYNC-1:0] raw;
   logic [NSYNC-1:0] s1_r;
   logic [NSYNC-1:0] s2_r;
   logic [NSYNC-1:0] s3_r;
   logic [NSYNC-1:0] flt_r;
   logic [NSYNC-1:0] flt_nxt;
   assign raw = {gate_req_i, supply_ov_cmp_i, line_low_cmp_i, overtemp_cmp_i, sense_ov_cmp_i,
                 sense_uv_cmp_i, diode_end_i, current_limit_cmp_i, diode_short_cmp_i,
                 sense_short_cmp_i, supply_off_thr_i, startup_reenable_threshold_i,
                 supply_on_thr_i, 2'b00};
   assign flt_nxt = ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & flt_r);
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         flt_r <= '0;
      end else if (ce_i) begin
         s1_r <= raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         flt_r <= flt_nxt;
      end
   end
   logic req_s, sov_s, llow_s, otp_s, vov_s, vuv_s, dend_s, clim_s, dsh_s, csh_s;
   logic voff_s, vre_s, von_s;
   assign {req_s, sov_s, llow_s, otp_s, vov_s, vuv_s, dend_s, clim_s, dsh_s, csh_s,
           voff_s, vre_s, von_s} = flt_r[NSYNC-1:2];

   // ===========================================
   // Edge and cycle detection
   // The combinational pulse terminators still pass through the sync delay; analog
   // hardware is expected to hold a faster path outside this block.
   logic req_d_r;
   logic dend_d_r;
   wire cyc_start = req_s & ~req_d_r;
   wire dend_fall = ~dend_s & dend_d_r;

   // ===========================================
   // Fault counters
   logic [CNT_W-1:0] sov_cnt_r;
   logic [CNT_W-1:0] bo_cnt_r;
   logic [CNT_W-1:0] blank_cnt_r;
   logic [1:0] vov_cnt_r;
   logic [1:0] csh_cnt_r;
   logic [7:0] uv_cnt_r;
   logic vov_seen_r;
   logic csh_seen_r;
   logic uv_sample_r;
   logic pulse_kill_r;
   logic dsh_pend_r;
   wire blanked = blank_cnt_r != BL_LIM;
   wire sov_fault = sov_s && (sov_cnt_r == OV_LIM);
   wire bo_fault = bo_cnt_r == BO_LIM;
   wire otp_fault = otp_s;
   wire vov_fault = cyc_start && vov_seen_r && (vov_cnt_r == OVC_LIM);
   wire csh_fault = cyc_start && csh_seen_r && (csh_cnt_r == SHC_LIM);
   wire uv_fault = !blanked && cyc_start && uv_sample_r
                   && (uv_cnt_r >= undervoltage_cycle_count_i);
   wire dsh_fault = dsh_pend_r && cyc_start;
   wire normal_fault = sov_fault | bo_fault | otp_fault | vov_fault | csh_fault | dsh_fault;

   // ===========================================
   // Supervisor state machine
   fault_pkg::sup_state_t st_r;
   fault_pkg::sup_state_t st_nxt;
   logic ext_r;
   logic ext_nxt;
   logic [1:0] loop_r;
   logic [1:0] loop_nxt;
   wire running = (st_r == fault_pkg::ST_RUN);
   always_comb begin
      st_nxt = st_r;
      ext_nxt = ext_r;
      loop_nxt = loop_r;
      unique case (st_r)
         fault_pkg::ST_RUN: begin
            if (normal_fault) begin
               st_nxt = fault_pkg::ST_RESTART;
               ext_nxt = 1'b0;
            end else if (uv_fault) begin
               st_nxt = fault_pkg::ST_RESTART;
               ext_nxt = 1'b1;
               loop_nxt = '0;
            end
         end
         fault_pkg::ST_RESTART: begin
            // The extended sequence skips the deep state; it only loops on the rail flags.
            if (!ext_r && voff_s) st_nxt = fault_pkg::ST_DEEP;
            else if (ext_r && vre_s) st_nxt = fault_pkg::ST_CHARGE;
         end
         fault_pkg::ST_DEEP: begin
            if (vre_s) st_nxt = fault_pkg::ST_CHARGE;
         end
         fault_pkg::ST_CHARGE: begin
            if (von_s) begin
               if (ext_r && (loop_r != EXT_LOOPS - 2'd1)) begin
                  st_nxt = fault_pkg::ST_RESTART;
                  loop_nxt = loop_r + 2'd1;
               end else begin
                  st_nxt = fault_pkg::ST_RUN;
                  ext_nxt = 1'b0;
               end
            end
         end
         default: st_nxt = fault_pkg::ST_RESTART;
      endcase
   end

   wire [5:0] cause_nxt = {csh_fault | dsh_fault, uv_fault & ~normal_fault, vov_fault,
                           otp_fault, bo_fault, sov_fault};

   // ===========================================
   // Sequential logic
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_d_r <= 1'b0;
         dend_d_r <= 1'b0;
         sov_cnt_r <= '0;
         bo_cnt_r <= '0;
         blank_cnt_r <= '0;
         vov_cnt_r <= '0;
         csh_cnt_r <= '0;
         uv_cnt_r <= fault_pkg::UNDERVOLTAGE_CYCLE_RESET;
         vov_seen_r <= 1'b0;
         csh_seen_r <= 1'b0;
         uv_sample_r <= 1'b0;
         pulse_kill_r <= 1'b0;
         dsh_pend_r <= 1'b0;
         st_r <= fault_pkg::ST_CHARGE;
         ext_r <= 1'b0;
         loop_r <= '0;
         fault_cause_o <= '0;
      end else if (ce_i) begin
         req_d_r <= req_s;
         dend_d_r <= dend_s;
         st_r <= st_nxt;
         ext_r <= ext_nxt;
         loop_r <= loop_nxt;
         if (running && normal_fault) fault_cause_o <= cause_nxt;
         else if (running && uv_fault) fault_cause_o <= cause_nxt;
         if (blanked) blank_cnt_r <= blank_cnt_r + 1'b1;
         sov_cnt_r <= !sov_s ? '0 : (sov_cnt_r == OV_LIM) ? sov_cnt_r : sov_cnt_r + 1'b1;
         // Brownout only counts while the gate request is high and the line current reads low.
         if (req_s && running) begin
            if (!llow_s) bo_cnt_r <= '0;
            else if (bo_cnt_r != BO_LIM) bo_cnt_r <= bo_cnt_r + 1'b1;
         end
         if (!running) bo_cnt_r <= '0;
         if (dend_fall) uv_sample_r <= vuv_s;
         if (vov_s) vov_seen_r <= 1'b1;
         if (csh_s) csh_seen_r <= 1'b1;
         if (cyc_start) begin
            vov_seen_r <= vov_s;
            csh_seen_r <= csh_s;
            vov_cnt_r <= !vov_seen_r ? '0 : (vov_cnt_r == OVC_LIM) ? vov_cnt_r
                         : vov_cnt_r + 2'd1;
            csh_cnt_r <= !csh_seen_r ? '0 : (csh_cnt_r == SHC_LIM) ? csh_cnt_r
                         : csh_cnt_r + 2'd1;
            uv_cnt_r <= (!uv_sample_r || blanked) ? '0 : (uv_cnt_r == 8'hff) ? uv_cnt_r
                        : uv_cnt_r + 8'h01;
            pulse_kill_r <= 1'b0;
            if (dsh_pend_r) dsh_pend_r <= 1'b0;
         end
         if (clim_s && req_s) pulse_kill_r <= 1'b1;
         if (dsh_s && req_s) begin
            pulse_kill_r <= 1'b1;
            dsh_pend_r <= 1'b1;
         end
         if (!running) begin
            vov_cnt_r <= '0;
            csh_cnt_r <= '0;
            uv_cnt_r <= '0;
            dsh_pend_r <= 1'b0;
         end
      end
   end

   // ===========================================
   // Registered outputs
   wire gate_nxt = running && st_nxt == fault_pkg::ST_RUN && req_s && !pulse_kill_r
                   && !clim_s && !dsh_s;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gate_o <= 1'b0;
         startup_source_en_o <= 1'b1;
         deep_low_current_state_o <= 1'b0;
         low_current_o <= 1'b0;
         restart_active_o <= 1'b0;
         extended_restart_o <= 1'b0;
      end else if (ce_i) begin
         gate_o <= gate_nxt;
         startup_source_en_o <= (st_nxt == fault_pkg::ST_CHARGE);
         deep_low_current_state_o <= (st_nxt == fault_pkg::ST_DEEP);
         low_current_o <= ext_nxt && (st_nxt != fault_pkg::ST_RUN);
         restart_active_o <= (st_nxt != fault_pkg::ST_RUN);
         extended_restart_o <= ext_nxt;
      end
   end
endmodule : flyback_fault_supervisor

// ===== flyback_fault_supervisor_chk.sv
// Port assertions for the fault supervisor.
`timescale 1ns/10ps
module flyback_fault_supervisor_chk #(
   parameter int unsigned BROWNOUT_CYC = 50,
   parameter int unsigned UV_BLANK_CYC = 100,
   parameter int unsigned CNT_W = 24
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic supply_ov_cmp_i,
   input wire logic overtemp_cmp_i,
   input wire logic current_limit_cmp_i,
   input wire logic diode_short_cmp_i,
   input wire logic supply_off_thr_i,
   input wire logic startup_reenable_threshold_i,
   input wire logic gate_o,
   input wire logic startup_source_en_o,
   input wire logic deep_low_current_state_o,
   input wire logic low_current_o,
   input wire logic restart_active_o,
   input wire logic extended_restart_o,
   input wire logic [5:0] fault_cause_o
);
   // ==========
   // Run lengths. Raw flags lead the synchronised ones, so these only overcount.
   logic [14:0] ov_run_r;
   logic [31:0] since_rst_r;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ov_run_r <= 15'h0000;
         since_rst_r <= 32'h0000_0000;
      end else begin
         ov_run_r <= supply_ov_cmp_i ? ov_run_r + 15'h0001 : 15'h0000;
         since_rst_r <= since_rst_r + 32'h0000_0001;
      end
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   a_restart_gate_off: assert property (restart_active_o |-> !gate_o)
      else $error("gate on in restart");
   a_climit_cut: assert property (current_limit_cmp_i [*8] |=> !gate_o)
      else $error("limit left gate on");
   a_dshort_cut: assert property (diode_short_cmp_i [*8] |=> !gate_o)
      else $error("diode short left gate on");
   a_otp_restart: assert property ((overtemp_cmp_i && !startup_source_en_o) [*8]
      |=> restart_active_o)
      else $error("overtemp ignored");
   a_deep_entry: assert property ((restart_active_o && !extended_restart_o && !startup_source_en_o
      && supply_off_thr_i) [*8] |=> deep_low_current_state_o || startup_source_en_o)
      else $error("no deep state");
   a_reenable_src: assert property ((restart_active_o && startup_reenable_threshold_i) [*8]
      |=> startup_source_en_o)
      else $error("startup source off");
   a_ext_low_cur: assert property (extended_restart_o && $past(extended_restart_o)
      |-> low_current_o && !gate_o)
      else $error("extended restart current");
   a_ovp_debounce: assert property ($rose(fault_cause_o[0]) |-> ov_run_r >= 15'h36b0)
      else $error("supply OV too early");
   a_uv_blank: assert property ($rose(fault_cause_o[4]) |-> since_rst_r >= UV_BLANK_CYC)
      else $error("UV inside blanking");
   a_cause_restart: assert property ($changed(fault_cause_o) && fault_cause_o != 6'h00
      |-> ##[0:2] restart_active_o)
      else $error("fault without restart");
endmodule : flyback_fault_supervisor_chk
bind flyback_fault_supervisor flyback_fault_supervisor_chk #(.BROWNOUT_CYC(BROWNOUT_CYC),
   .UV_BLANK_CYC(UV_BLANK_CYC), .CNT_W(CNT_W)) chk_i (.mclk_i, .rst_n_i, .supply_ov_cmp_i,
   .overtemp_cmp_i, .current_limit_cmp_i, .diode_short_cmp_i, .supply_off_thr_i,
   .startup_reenable_threshold_i, .gate_o, .startup_source_en_o, .deep_low_current_state_o,
   .low_current_o, .restart_active_o, .extended_restart_o, .fault_cause_o);

// ===== power_stage_model.sv
// Behavioural power stage: gate request timing and supply rail flags.
`timescale 1ns/10ps
module power_stage_model (
   input wire logic mclk_i,
   input wire logic drive_i,
   input wire logic src_en_i,
   output logic gate_req_o,
   output logic diode_end_o,
   output logic off_thr_o,
   output logic reen_thr_o,
   output logic on_thr_o
);
   // ==========
   // Rail: the source charges it, switching holds it, an idle gate drains it.
   int ph = 0;
   int vdd = 0;
   int idle = 0;
   assign gate_req_o = (ph < 10);
   assign diode_end_o = (ph >= 12) && (ph < 27);
   assign off_thr_o = (vdd <= 55);
   assign reen_thr_o = (vdd <= 40);
   assign on_thr_o = (vdd >= 172);
   always @(negedge mclk_i) begin
      ph <= (ph == 39) ? 0 : ph + 1;
      idle <= drive_i ? 0 : idle + 1;
      if (src_en_i && vdd < 180) begin
         vdd <= vdd + 1;
      end else if (!src_en_i && idle > 64 && vdd > 0) begin
         vdd <= vdd - 1;
      end
   end
endmodule : power_stage_model

// ===== flyback_fault_supervisor_tb_top.sv
// Self-checking bench for the fault supervisor.
`timescale 1ns/10ps
module flyback_fault_supervisor_tb_top;
   logic mclk_i;
   logic rst_n_i;
   logic [7:0] flt;
   logic req, dend, off_thr, reen_thr, on_thr;
   logic gate, src, deep, lowc, rst_act, ext, seen_deep, seen_ext, hit;
   logic [5:0] cause;
   int bad_count = 0;
   int checked = 0;
   int lens[10] = '{13000, 45, 200, 14100, 400, 20, 200, 300, 200, 200};
   int idxs[10] = '{0, 3, 7, 0, 1, 2, 3, 4, 5, 6};
   logic [5:0] causes[10] = '{6'h00, 6'h00, 6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h20};
   flyback_fault_supervisor #(.BROWNOUT_CYC(50), .UV_BLANK_CYC(100)) DUT (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .gate_req_i(req),
      .supply_ov_cmp_i(flt[0]), .line_low_cmp_i(flt[1]), .overtemp_cmp_i(flt[2]),
      .sense_ov_cmp_i(flt[3]), .sense_uv_cmp_i(flt[4]), .diode_end_i(dend),
      .current_limit_cmp_i(flt[7]), .diode_short_cmp_i(flt[5]), .sense_short_cmp_i(flt[6]),
      .supply_off_thr_i(off_thr), .startup_reenable_threshold_i(reen_thr),
      .supply_on_thr_i(on_thr), .undervoltage_cycle_count_i(8'h03), .gate_o(gate),
      .startup_source_en_o(src), .deep_low_current_state_o(deep), .low_current_o(lowc),
      .restart_active_o(rst_act), .extended_restart_o(ext), .fault_cause_o(cause));
   power_stage_model stage (.mclk_i(mclk_i), .drive_i(gate), .src_en_i(src), .gate_req_o(req),
      .diode_end_o(dend), .off_thr_o(off_thr), .reen_thr_o(reen_thr), .on_thr_o(on_thr));
   task automatic compare(input logic [5:0] got, input logic [5:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : compare
   task automatic wait_gate(output logic ok);
      ok = 1'b0;
      for (int n = 0; n < 4000 && !ok; n++) begin
         @(negedge mclk_i);
         ok = (gate === 1'b1);
      end
   endtask : wait_gate
   task automatic pulse(input int i, input int n);
      flt[i] = 1'b1;
      repeat (n) @(negedge mclk_i);
      flt[i] = 1'b0;
      repeat (20) @(negedge mclk_i);
   endtask : pulse
   task automatic print_verdict();
      if (bad_count == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   always @(negedge mclk_i) begin
      if (deep === 1'b1) seen_deep = 1'b1;
      if (ext === 1'b1) seen_ext = 1'b1;
   end
   initial begin
      flt = 8'h00;
      rst_n_i = 1'b0;
      repeat (16) @(negedge mclk_i);
      rst_n_i = 1'b1;
      wait_gate(hit);
      compare({5'h00, hit}, 6'h01);
      for (int k = 0; k < 10; k++) begin
         seen_deep = 1'b0;
         seen_ext = 1'b0;
         pulse(idxs[k], lens[k]);
         compare({5'h00, rst_act}, {5'h00, causes[k] != 6'h00});
         wait_gate(hit);
         compare({3'h0, seen_deep, seen_ext, hit}, {3'h0, causes[k] != 6'h00 && idxs[k] != 4,
            idxs[k] == 4, 1'b1});
         compare(cause, causes[k]);
      end
      print_verdict();
   end
   // Watchdog at roughly three times the expected run length.
   initial begin
      repeat (90000) @(posedge mclk_i);
      bad_count++;
      print_verdict();
   end
endmodule : flyback_fault_supervisor_tb_top
